// *** include/rtd_defs.vh ***
`ifndef RTD_DEFS_VH
`define RTD_DEFS_VH

// timing
`define RTD_CLK_HZ 40000000
`define RTD_ROT_PERIOD_MS 2000
`define RTD_ROT_CYCLES (`RTD_ROT_PERIOD_MS * (`RTD_CLK_HZ / 1000))

// rotation slots: groups 0..5, then points 1..16 at slots 6..21
`define RTD_NUM_POINTS 16
`define RTD_FIRST_POINT_SLOT 5'h06
`define RTD_LAST_SLOT 5'h15

// group enable bit positions in the control register
`define RTD_GRP_CURRENTS 0
`define RTD_GRP_LINE_VOLTS 1
`define RTD_GRP_PHASE_VOLTS 2
`define RTD_GRP_POWER 3
`define RTD_GRP_FREQUENCY 4
`define RTD_GRP_DIFF 5
`define RTD_CTRL_RESET 6'h1B

// register byte addresses and regions
`define RTD_ADDR_CTRL 12'h000
`define RTD_ADDR_STATUS 12'h004
`define RTD_ADDR_PSTATE 12'h008
`define RTD_CFG_REGION 6'h01
`define RTD_MASK_REGION 6'h02
`define RTD_MSG_REGION 3'h1

// status register fields
`define RTD_STAT_VALID 8
`define RTD_STAT_FIT 9
`define RTD_STAT_BUSY 10

// point configuration: mode in [1:0], invert in bit 2
`define RTD_MODE_CONST0 2'h0
`define RTD_MODE_CONST1 2'h1
`define RTD_MODE_OR 2'h2
`define RTD_MODE_AND 2'h3
`define RTD_CFG_INV 2
`define RTD_CFG_RESET 3'h0
`define RTD_MASK_RESET 32'h00000000

// characters that count as empty
`define RTD_CHAR_NUL 8'h00
`define RTD_CHAR_SPACE 8'h20

`endif

// *** rtl/rtd_tick.v ***
`include "rtd_defs.vh"

module rtd_tick #(
  parameter PERIOD = `RTD_ROT_CYCLES
) (
  input wire clk_i,
  input wire reset_i,
  output reg tick_o
);

  localparam [31:0] LAST = PERIOD - 1;

  reg [31:0] count_q;

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      count_q <= 32'h0;
      tick_o <= 1'b0;
    end
    else if (count_q == LAST)
    begin
      count_q <= 32'h0;
      tick_o <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 32'h1;
      tick_o <= 1'b0;
    end
  end

endmodule // rtd_tick

// *** rtl/rtd_display.v ***
// Contract
// R1: show enabled items in turn, every 2 s
// R2: currents group when its setting is set
// R3: line voltages group when setting set
// R4: phase voltages group when setting set
// R5: power group when its setting is set
// R6: frequency group when its setting is set
// R7: differential group only if inputs fitted
// R8: sixteen points, two messages each
// R9: point state selects true or false message
// R10: host writes and reads back messages
// R11: equation uses any status bit combination
// R12: blank selected message shows nothing
// R13: constant equation shows message every cycle
// R14: default groups currents, line, power, frequency
// R15: skip slots with nothing to show
// R16: fixed order groups then points, wrapping
`include "rtd_defs.vh"

module rtd_display #(
  parameter ROT_CYCLES = `RTD_ROT_CYCLES
) (
  input wire clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire [31:0] status_bits_i,
  input wire diff_fitted_i,
  input wire [3:0] disp_char_addr_i,
  output reg [4:0] disp_item_o,
  output reg disp_valid_o,
  output reg [7:0] disp_char_o
);

  localparam S_IDLE = 1'b0;
  localparam S_SCAN = 1'b1;

  function point_eval;
    input [1:0] mode;
    input inv;
    input [31:0] mask;
    input [31:0] bits;
    reg r;
    begin
      case (mode)
        `RTD_MODE_CONST0: r = 1'b0;
        `RTD_MODE_CONST1: r = 1'b1;
        `RTD_MODE_OR: r = |(mask & bits);
        default: r = &(~mask | bits);
      endcase
      point_eval = r ^ inv;
    end
  endfunction

  function word_nonblank;
    input [31:0] w;
    integer b;
    reg nz;
    begin
      nz = 1'b0;
      for (b = 0; b < 4; b = b + 1)
      begin
        if (w[8*b +: 8] != `RTD_CHAR_NUL && w[8*b +: 8] != `RTD_CHAR_SPACE)
          nz = 1'b1;
      end
      word_nonblank = nz;
    end
  endfunction

  function [4:0] slot_next;
    input [4:0] s;
    begin
      if (s == `RTD_LAST_SLOT)
        slot_next = 5'h00;
      else
        slot_next = s + 5'h01;
    end
  endfunction

  reg [5:0] ctrl_q;
  reg [2:0] cfg_q [0:`RTD_NUM_POINTS-1];
  reg [31:0] mask_q [0:`RTD_NUM_POINTS-1];
  reg [31:0] msg_mem [0:127];
  reg [127:0] word_nz_q;
  reg fit_s1_q;
  reg fit_q;
  reg state_q;
  reg [4:0] cur_q;
  reg [4:0] cand_q;
  reg [4:0] tries_q;
  reg show_q;
  reg pslverr_q;
  reg [15:0] pt_state;
  reg [15:0] pt_text;
  reg [31:0] rd_val;
  reg rd_err;
  reg [7:0] char_d;
  integer i;
  integer j;

  wire tick;
  wire setup = psel_i & ~penable_i;
  wire wr = psel_i & penable_i & pwrite_i;
  wire [21:0] slot_has;
  wire [4:0] pt_off = cur_q - `RTD_FIRST_POINT_SLOT;
  wire [3:0] cur_pt = pt_off[3:0];
  wire [31:0] cur_word;

  rtd_tick #(
    .PERIOD(ROT_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_o(tick)
  );

  // hardware option strap, brought into the clock domain
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      fit_s1_q <= 1'b0;
      fit_q <= 1'b0;
    end
    else
    begin
      fit_s1_q <= diff_fitted_i;
      fit_q <= fit_s1_q;
    end
  end

  // live point states and whether the selected message has text
  always @*
  begin
    for (i = 0; i < `RTD_NUM_POINTS; i = i + 1)
    begin
      pt_state[i] = point_eval(cfg_q[i][1:0], cfg_q[i][`RTD_CFG_INV],
                               mask_q[i], status_bits_i); // see R11 see R13
      pt_text[i] = |word_nz_q[i*8 + (pt_state[i] ? 4 : 0) +: 4]; // see R9
    end
  end

  // a slot has content if its group is enabled (differential only when fitted) or its selected message is not blank
  assign slot_has = {pt_text, // see R12 see R15
                     ctrl_q[5] & fit_q, // see R7
                     ctrl_q[4:0]}; // see R2 see R3 see R4 see R5 see R6

  // register read decode
  always @*
  begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    if (paddr_i == `RTD_ADDR_CTRL)
      rd_val = {26'h0, ctrl_q};
    else if (paddr_i == `RTD_ADDR_STATUS)
    begin
      rd_val[4:0] = cur_q;
      rd_val[`RTD_STAT_VALID] = disp_valid_o;
      rd_val[`RTD_STAT_FIT] = fit_q;
      rd_val[`RTD_STAT_BUSY] = state_q;
    end
    else if (paddr_i == `RTD_ADDR_PSTATE)
      rd_val = {16'h0, pt_state};
    else if (paddr_i[11:6] == `RTD_CFG_REGION)
      rd_val = {29'h0, cfg_q[paddr_i[5:2]]};
    else if (paddr_i[11:6] == `RTD_MASK_REGION)
      rd_val = mask_q[paddr_i[5:2]];
    else if (paddr_i[11:9] == `RTD_MSG_REGION)
      rd_val = msg_mem[paddr_i[8:2]]; // see R10
    else
      rd_err = 1'b1;
  end

  // zero-wait slave: data and error captured in the setup cycle
  assign pready_o = 1'b1;
  assign pslverr_o = pslverr_q & psel_i & penable_i;

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      prdata_o <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_o <= pwrite_i ? 32'h0 : rd_val;
      pslverr_q <= rd_err;
    end
  end

  // settings registers
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= `RTD_CTRL_RESET; // see R14
      word_nz_q <= 128'h0;
      for (j = 0; j < `RTD_NUM_POINTS; j = j + 1)
      begin
        cfg_q[j] <= `RTD_CFG_RESET;
        mask_q[j] <= `RTD_MASK_RESET;
      end
    end
    else if (wr)
    begin
      if (paddr_i == `RTD_ADDR_CTRL)
        ctrl_q <= pwdata_i[5:0];
      else if (paddr_i[11:6] == `RTD_CFG_REGION)
        cfg_q[paddr_i[5:2]] <= pwdata_i[2:0];
      else if (paddr_i[11:6] == `RTD_MASK_REGION)
        mask_q[paddr_i[5:2]] <= pwdata_i;
      else if (paddr_i[11:9] == `RTD_MSG_REGION)
        word_nz_q[paddr_i[8:2]] <= word_nonblank(pwdata_i); // see R12
    end
  end

  // message text: 16 points x 2 messages x 4 words, no reset
  always @(posedge clk_i)
  begin
    if (wr && paddr_i[11:9] == `RTD_MSG_REGION)
      msg_mem[paddr_i[8:2]] <= pwdata_i; // see R8 see R10
  end

  // rotation: on each tick search forward for the next slot with content
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_q <= S_SCAN;
      // start at slot 0 so the shown item does not jump after reset
      cur_q <= 5'h00;
      cand_q <= 5'h00;
      tries_q <= 5'h00;
      show_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          if (tick)
          begin
            cand_q <= slot_next(cur_q); // see R1 see R16
            tries_q <= 5'h00;
            state_q <= S_SCAN;
          end
        end
        default:
        begin
          if (slot_has[cand_q])
          begin
            cur_q <= cand_q;
            show_q <= 1'b1;
            state_q <= S_IDLE;
          end
          else if (tries_q == `RTD_LAST_SLOT)
          begin
            show_q <= 1'b0;
            state_q <= S_IDLE;
          end
          else
          begin
            cand_q <= slot_next(cand_q); // see R15 see R16
            tries_q <= tries_q + 5'h01;
          end
        end
      endcase
    end
  end

  // text of the shown point follows its live state
  assign cur_word = msg_mem[{cur_pt, pt_state[cur_pt],
                             disp_char_addr_i[3:2]}]; // see R9

  always @*
  begin
    case (disp_char_addr_i[1:0])
      2'h0: char_d = cur_word[7:0];
      2'h1: char_d = cur_word[15:8];
      2'h2: char_d = cur_word[23:16];
      default: char_d = cur_word[31:24];
    endcase
    if (cur_q < `RTD_FIRST_POINT_SLOT)
      char_d = `RTD_CHAR_NUL;
  end

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      disp_item_o <= 5'h00;
      disp_valid_o <= 1'b0;
      disp_char_o <= `RTD_CHAR_NUL;
    end
    else
    begin
      disp_item_o <= cur_q;
      disp_valid_o <= show_q & slot_has[cur_q]; // see R12
      disp_char_o <= char_d;
    end
  end

endmodule // rtd_display

// *** sim/rtd_panel_model.sv ***
module rtd_panel_model (
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] char_i,
  output logic [3:0] addr_o,
  output logic [31:0] head_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] seen_q = 4'h0;
  // sweep all characters, keep the first four
  always @(posedge clk_i)
  begin
    addr_o <= reset_i ? 4'h0 : addr_o + 4'h1;
    seen_q <= addr_o;
    if (seen_q < 4'h4)
      head_o[8*seen_q +: 8] <= char_i;
  end
endmodule // rtd_panel_model

// *** sim/rtd_display_sva.sv ***
module rtd_display_sva (
  input wire clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire diff_fitted_i,
  input wire [4:0] disp_item_o,
  input wire disp_valid_o,
  input wire [7:0] disp_char_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_release;
    $fell(reset_i);
  endsequence
  sequence s_first_shown;
    ##[1:8] (disp_valid_o && disp_item_o == 5'h00);
  endsequence
  a_settle_default: assert property (s_release |-> s_first_shown)
    else $error("first item after reset wrong");
  a_ready_high: assert property (pready_o)
    else $error("ready low");
  a_err_access: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access");
  a_item_range: assert property (disp_item_o <= 5'h15)
    else $error("item out of range");
  a_item_hold: assert property (
    $changed(disp_item_o) |=> $stable(disp_item_o) [*8])
    else $error("item changed too soon");
  a_group_blank: assert property (
    disp_item_o < 5'h06 && $past(disp_item_o) < 5'h06
    |-> disp_char_o == 8'h00)
    else $error("group slot has text");
  a_diff_gate: assert property (
    disp_item_o == 5'h05 && disp_valid_o
    |-> diff_fitted_i || $past(diff_fitted_i, 8))
    else $error("differential shown unfitted");
  a_reset_clear: assert property (disable iff (1'b0)
    reset_i |=> disp_item_o == 5'h00 && !disp_valid_o
    && disp_char_o == 8'h00)
    else $error("display not cleared");
endmodule // rtd_display_sva
bind rtd_display rtd_display_sva i_rtd_display_sva (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .diff_fitted_i(diff_fitted_i),
  .disp_item_o(disp_item_o),
  .disp_valid_o(disp_valid_o),
  .disp_char_o(disp_char_o)
);

// *** sim/rotating_text_display_tb.sv ***
`include "rtd_defs.vh"
module rotating_text_display_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ROT = 40;
  localparam logic [31:0] CFG_R [7] = '{0, 1, 2, 2, 3, 7, 3};
  localparam logic [31:0] MASK_R [7] = '{0, 0, 32'h0000000F,
    32'h0000F000, 32'h00000F04, 32'h00000F04, 32'h00000F05};
  localparam logic EXP_R [7] = '{0, 1, 1, 0, 1, 0, 0};
  localparam logic [4:0] ORDER_R [5] = '{0, 1, 3, 4, 0};
  logic clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic fitted = 0, pready, perr, err, valid;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, status = 32'h00000F04, prdata, rd, head;
  logic [3:0] caddr;
  logic [4:0] item;
  logic [7:0] char;
  int errors = 0, n_compared = 0;
  rtd_display #(.ROT_CYCLES(ROT)) i_rtd_display (.clk_i(clk_i),
    .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .status_bits_i(status), .diff_fitted_i(fitted),
    .disp_char_addr_i(caddr), .disp_item_o(item),
    .disp_valid_o(valid), .disp_char_o(char));
  rtd_panel_model i_rtd_panel_model (.clk_i(clk_i), .reset_i(reset_i),
    .char_i(char), .addr_o(caddr), .head_o(head));
  initial forever #12.5 clk_i = ~clk_i;
  task automatic complete_run;
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wait_item(input logic [4:0] it);
    int k;
    k = 0;
    while (!(valid === 1'b1 && item === it) && k < 200)
    begin
      @(posedge clk_i);
      k++;
    end
    chk(32'(item), 32'(it));
  endtask
  initial
  begin
    #(25 * 20000);
    errors++;
    complete_run;
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    reset_i <= 0;
    for (int i = 0; i < 7; i++)
    begin
      apb(1, 12'h040 + 12'(4 * i), CFG_R[i]);
      apb(1, 12'h080 + 12'(4 * i), MASK_R[i]);
    end
    apb(0, `RTD_ADDR_PSTATE, 0);
    for (int i = 0; i < 7; i++)
      chk(32'(rd[i]), 32'(EXP_R[i]));
    apb(0, `RTD_ADDR_CTRL, 0);
    chk(rd, 32'h0000001B);
    foreach (ORDER_R[i]) wait_item(ORDER_R[i]);
    apb(0, 12'hC00, 0);
    chk({rd[30:0], err}, 32'h1);
    for (int g = 0; g < 5; g++)
    begin
      apb(1, `RTD_ADDR_CTRL, 32'h1 << g);
      wait_item(5'(g));
      repeat (ROT) @(posedge clk_i);
      chk(32'(item), g);
    end
    apb(1, `RTD_ADDR_CTRL, 32'h20);
    repeat (2 * ROT) @(posedge clk_i);
    chk(32'(valid), 0);
    fitted <= 1;
    wait_item(5'h05);
    apb(0, `RTD_ADDR_STATUS, 0);
    chk(rd, 32'h00000305);
    apb(1, `RTD_ADDR_CTRL, 0);
    apb(1, 12'h310, 32'h44434241);
    apb(1, 12'h060, 1);
    wait_item(5'h0E);
    repeat (40) @(posedge clk_i);
    chk(head, 32'h44434241);
    apb(1, 12'h060, 0);
    repeat (2 * ROT) @(posedge clk_i);
    chk(32'(valid), 0);
    apb(1, 12'h300, 32'h5A595857);
    wait_item(5'h0E);
    repeat (40) @(posedge clk_i);
    chk(head, 32'h5A595857);
    apb(1, 12'h0A0, 1);
    apb(1, 12'h060, 2);
    status <= 32'h00000F05;
    repeat (60) @(posedge clk_i);
    chk(head, 32'h44434241);
    reset_i <= 1;
    repeat (2) @(posedge clk_i);
    reset_i <= 0;
    wait_item(5'h00);
    complete_run;
  end
endmodule // rotating_text_display_tb
